// *** shared/periph_irq_pkg.sv ***
// constants for the peripheral interrupt flag and enable block
`default_nettype none
package periph_irq_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // register addresses
   localparam logic [7:0] ADDR_CORE_IRQ_CONTROL = 8'h0B;
   localparam logic [7:0] ADDR_PERIPHERAL_IRQ_FLAGS = 8'h0C;
   localparam logic [7:0] ADDR_PERIPHERAL_IRQ_ENABLES = 8'h8C;
   localparam logic [7:0] ADDR_RESET_CAUSE_FLAGS = 8'h8E;

   // flag and enable share one layout
   localparam int BIT_ADC_DONE = 6;
   localparam int BIT_SERIAL_PORT = 3;
   localparam int BIT_CAPCMP = 2;
   localparam int BIT_PERIOD_MATCH = 1;
   localparam int BIT_WIDE_TIMER_OVF = 0;
   localparam logic [7:0] PERIPH_IMPL_MASK = 8'h4F;

   // core interrupt control: only the two enables live here
   localparam int BIT_GLOBAL_IRQ_ENABLE = 7;
   localparam int BIT_PERIPHERAL_GROUP_ENABLE = 6;
   localparam logic [7:0] CORE_CTL_IMPL_MASK = 8'hC0;

   // reset cause layout
   localparam int BIT_POWER_ON_FLAG = 1;
   localparam int BIT_BROWNOUT_FLAG = 0;

   // values after power-on reset
   localparam logic [7:0] RST_PERIPHERAL_IRQ_FLAGS = 8'h00;
   localparam logic [7:0] RST_PERIPHERAL_IRQ_ENABLES = 8'h00;
   localparam logic [7:0] RST_CORE_IRQ_CONTROL = 8'h00;
   localparam logic RST_POWER_ON_FLAG = 1'b0;
   localparam logic [7:0] RST_READ_DATA = 8'h00;
endpackage : periph_irq_pkg
`default_nettype wire

// *** hdl/peripheral_interrupt_flags.sv ***
// peripheral interrupt flags, enables, group/global gating and reset cause flags
`default_nettype none

// Summary of operation
// - enable register lives at address 8Ch
// - flag register lives at address 0Ch
// - bits 7,5,4 read zero, ignore writes
// - implemented bits read/write, zero after power-on
// - enable bit 6 gates A/D done
// - enable bit 3 gates serial port
// - enable bit 2 gates capture/compare unit
// - enable bit 1 gates period match
// - enable bit 0 gates wide timer overflow
// - group enable required for any peripheral request
// - flags set regardless of any enable
// - A/D flag set on completion, software clears
// - serial flag set on transfer end, software clears
// - capcmp flag on capture/compare, unused in PWM
// - overflow flag set, held until software clears
// - reset cause register at 8Eh
// - brown-out flag not initialised at power-on
// - brown-out reset clears brown-out flag only
// - global enable gates every interrupt
module peripheral_interrupt_flags
   import periph_irq_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic adc_done_evt,
   input wire logic serial_done_evt,
   input wire logic capcmp_evt,
   input wire logic capcmp_pwm_mode,
   input wire logic period_match_evt,
   input wire logic wide_timer_ovf_evt,
   input wire logic brownout_reset,
   output logic irq_req
);

   logic [7:0] flags_r;
   logic [7:0] flags_nxt;
   logic [7:0] enables_r;
   logic [7:0] enables_nxt;
   logic [7:0] core_ctl_r;
   logic [7:0] core_ctl_nxt;
   logic power_on_flag_r;
   logic power_on_flag_nxt;
   logic brownout_flag_r;
   logic brownout_flag_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic irq_r;
   logic irq_nxt;

   // address decode
   wire logic sel_flags = (reg_addr == ADDR_PERIPHERAL_IRQ_FLAGS);
   wire logic sel_enables = (reg_addr == ADDR_PERIPHERAL_IRQ_ENABLES);
   wire logic sel_core_ctl = (reg_addr == ADDR_CORE_IRQ_CONTROL);
   wire logic sel_reset_cause = (reg_addr == ADDR_RESET_CAUSE_FLAGS);
   wire logic wr_flags = reg_wr && sel_flags;
   wire logic wr_enables = reg_wr && sel_enables;
   wire logic wr_core_ctl = reg_wr && sel_core_ctl;
   wire logic wr_reset_cause = reg_wr && sel_reset_cause;

   // capture/compare events mean nothing while the unit runs PWM
   wire logic capcmp_set = capcmp_evt && !capcmp_pwm_mode;

   // event vector, flag layout; unimplemented positions stay zero
   wire logic [7:0] event_vec = {
      1'b0,
      adc_done_evt,
      2'b00,
      serial_done_evt,
      capcmp_set,
      period_match_evt,
      wide_timer_ovf_evt
   };

   // flags: a write stores, an event sets; the set beats a same-cycle clear
   wire logic [7:0] flags_base = wr_flags ? (reg_wdata & PERIPH_IMPL_MASK) : flags_r;
   assign flags_nxt = flags_base | event_vec;

   assign enables_nxt = wr_enables ? (reg_wdata & PERIPH_IMPL_MASK) : enables_r;
   assign core_ctl_nxt = wr_core_ctl ? (reg_wdata & CORE_CTL_IMPL_MASK) : core_ctl_r;

   // brown-out reset drops only the brown-out flag; it overrides a write
   assign power_on_flag_nxt = wr_reset_cause ? reg_wdata[BIT_POWER_ON_FLAG] : power_on_flag_r;
   assign brownout_flag_nxt = brownout_reset ? 1'b0 :
                              wr_reset_cause ? reg_wdata[BIT_BROWNOUT_FLAG] : brownout_flag_r;

   // request computed from next state so the registered output tracks
   // the registers with no extra cycle of lag
   wire logic [7:0] pending_nxt = flags_nxt & enables_nxt;
   wire logic group_en_nxt = core_ctl_nxt[BIT_PERIPHERAL_GROUP_ENABLE];
   wire logic global_en_nxt = core_ctl_nxt[BIT_GLOBAL_IRQ_ENABLE];
   assign irq_nxt = (|pending_nxt) && group_en_nxt && global_en_nxt;

   // read mux; unmapped addresses read zero
   wire logic [7:0] reset_cause_view = {
      6'h00,
      power_on_flag_r,
      brownout_flag_r
   };
   wire logic [7:0] read_mux = sel_flags ? flags_r :
                               sel_enables ? enables_r :
                               sel_core_ctl ? core_ctl_r :
                               sel_reset_cause ? reset_cause_view : 8'h00;
   // data stands only in the cycle after the strobe
   assign rdata_nxt = reg_rd ? read_mux : 8'h00;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         flags_r <= RST_PERIPHERAL_IRQ_FLAGS;
         enables_r <= RST_PERIPHERAL_IRQ_ENABLES;
         core_ctl_r <= RST_CORE_IRQ_CONTROL;
         power_on_flag_r <= RST_POWER_ON_FLAG;
         rdata_r <= RST_READ_DATA;
         irq_r <= 1'b0;
      end else begin
         flags_r <= flags_nxt;
         enables_r <= enables_nxt;
         core_ctl_r <= core_ctl_nxt;
         power_on_flag_r <= power_on_flag_nxt;
         rdata_r <= rdata_nxt;
         irq_r <= irq_nxt;
      end
   end

   // left out of power-on reset on purpose: its value then is undefined
   always_ff @(posedge mclk) begin
      brownout_flag_r <= brownout_flag_nxt;
   end

   assign reg_rdata = rdata_r;
   assign irq_req = irq_r;

   // helper state for the checks below
   logic past_valid_r;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         past_valid_r <= 1'b0;
      end else begin
         past_valid_r <= 1'b1;
      end
   end

   wire logic group_en = core_ctl_r[BIT_PERIPHERAL_GROUP_ENABLE];
   wire logic global_en = core_ctl_r[BIT_GLOBAL_IRQ_ENABLE];

   AST_UNIMPL_ZERO: assert property (
      @(posedge mclk) disable iff (!rst_b)
      ((flags_r & ~PERIPH_IMPL_MASK) == 8'h00) && ((enables_r & ~PERIPH_IMPL_MASK) == 8'h00))
      else $error("unimplemented flag or enable bit is set");

   AST_FLAGS_READ_ADDR: assert property (
      @(posedge mclk) disable iff (!rst_b)
      reg_rd && reg_addr == 8'h0C |=> reg_rdata == $past(flags_r))
      else $error("flag register read returned wrong data");

   AST_ENABLES_WRITE_READ: assert property (
      @(posedge mclk) disable iff (!rst_b)
      reg_wr && reg_addr == 8'h8C ##1 reg_rd && reg_addr == 8'h8C
      |=> reg_rdata == ($past(reg_wdata, 2) & 8'h4F))
      else $error("enable register write did not read back masked");

   AST_ENABLES_HOLD: assert property (
      @(posedge mclk) disable iff (!rst_b)
      !(reg_wr && sel_enables) |=> $stable(enables_r))
      else $error("enable register changed without a write");

   AST_RDATA_ONE_CYCLE: assert property (
      @(posedge mclk) disable iff (!rst_b)
      !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data present without a read strobe");

   AST_ADC_ENABLE_BLOCKS: assert property (
      @(posedge mclk) disable iff (!rst_b)
      flags_r == 8'h40 && !enables_r[6] |-> !irq_req)
      else $error("A/D request passed with its enable clear");

   AST_SERIAL_ENABLE_BLOCKS: assert property (
      @(posedge mclk) disable iff (!rst_b)
      flags_r == 8'h08 && !enables_r[3] |-> !irq_req)
      else $error("serial request passed with its enable clear");

   AST_CAPCMP_ENABLE_BLOCKS: assert property (
      @(posedge mclk) disable iff (!rst_b)
      flags_r == 8'h04 && !enables_r[2] |-> !irq_req)
      else $error("capture/compare request passed with its enable clear");

   AST_PERIOD_ENABLE_BLOCKS: assert property (
      @(posedge mclk) disable iff (!rst_b)
      flags_r == 8'h02 && !enables_r[1] |-> !irq_req)
      else $error("period match request passed with its enable clear");

   AST_OVF_ENABLE_BLOCKS: assert property (
      @(posedge mclk) disable iff (!rst_b)
      flags_r == 8'h01 && !enables_r[0] |-> !irq_req)
      else $error("overflow request passed with its enable clear");

   AST_GROUP_GATES: assert property (
      @(posedge mclk) disable iff (!rst_b)
      !group_en |-> !irq_req)
      else $error("request raised with group enable clear");

   AST_GLOBAL_GATES: assert property (
      @(posedge mclk) disable iff (!rst_b)
      !global_en |-> !irq_req)
      else $error("request raised with global enable clear");

   AST_EVENT_SETS_ANYWAY: assert property (
      @(posedge mclk) disable iff (!rst_b)
      wide_timer_ovf_evt && enables_r == 8'h00 && !global_en |=> flags_r[0])
      else $error("masked overflow event did not set its flag");

   AST_ADC_SET_HOLD: assert property (
      @(posedge mclk) disable iff (!rst_b)
      adc_done_evt ##1 !(reg_wr && sel_flags) |=> flags_r[6])
      else $error("A/D flag not set or not held");

   AST_SERIAL_SET: assert property (
      @(posedge mclk) disable iff (!rst_b)
      serial_done_evt |=> flags_r[3])
      else $error("serial flag not set on transfer end");

   AST_CAPCMP_MODES: assert property (
      @(posedge mclk) disable iff (!rst_b)
      !flags_r[2] && !(reg_wr && sel_flags) |=> flags_r[2] == $past(capcmp_set))
      else $error("capture/compare flag wrong for the unit mode");

   AST_CAPCMP_PWM_IGNORED: assert property (
      @(posedge mclk) disable iff (!rst_b)
      capcmp_evt && capcmp_pwm_mode && !flags_r[2] && !(reg_wr && sel_flags) |=> !flags_r[2])
      else $error("capture/compare flag set in PWM mode");

   AST_OVF_STICKY: assert property (
      @(posedge mclk) disable iff (!rst_b)
      flags_r[0] && !(reg_wr && sel_flags) |=> flags_r[0] [*1] ##0 $stable(flags_r[0]))
      else $error("overflow flag dropped without a software write");

   AST_PERIOD_SET_WINS: assert property (
      @(posedge mclk) disable iff (!rst_b)
      period_match_evt && reg_wr && sel_flags && !reg_wdata[1] |=> flags_r[1])
      else $error("period match lost against a same-cycle clear");

   AST_RESET_CAUSE_ADDR: assert property (
      @(posedge mclk) disable iff (!rst_b)
      reg_rd && reg_addr == 8'h8E |=> reg_rdata[1] == $past(power_on_flag_r))
      else $error("reset cause read does not show the power-on flag");

   AST_BROWNOUT_CLEARS: assert property (
      @(posedge mclk) disable iff (!rst_b)
      brownout_reset && !wr_reset_cause
      |=> !brownout_flag_r && power_on_flag_r == $past(power_on_flag_r))
      else $error("brown-out reset handled wrongly");

   AST_IRQ_EQUATION: assert property (
      @(posedge mclk) disable iff (!rst_b)
      past_valid_r |-> irq_req == ((|(flags_r & enables_r)) && group_en && global_en))
      else $error("request does not match flag, enable and gating");

   // per-source permit, set and hold checks
   AST_ADC_ENABLE_PERMITS: assert property (
      @(posedge mclk) disable iff (!rst_b)
      flags_r[6] && enables_r[6] && group_en && global_en |-> irq_req)
      else $error("A/D request blocked with everything enabled");

   AST_SERIAL_ENABLE_PERMITS: assert property (
      @(posedge mclk) disable iff (!rst_b)
      flags_r[3] && enables_r[3] && group_en && global_en |-> irq_req)
      else $error("serial request blocked with everything enabled");

   AST_CAPCMP_ENABLE_PERMITS: assert property (
      @(posedge mclk) disable iff (!rst_b)
      flags_r[2] && enables_r[2] && group_en && global_en |-> irq_req)
      else $error("capture/compare request blocked with everything enabled");

   AST_PERIOD_ENABLE_PERMITS: assert property (
      @(posedge mclk) disable iff (!rst_b)
      flags_r[1] && enables_r[1] && group_en && global_en |-> irq_req)
      else $error("period match request blocked with everything enabled");

   AST_OVF_ENABLE_PERMITS: assert property (
      @(posedge mclk) disable iff (!rst_b)
      flags_r[0] && enables_r[0] && group_en && global_en |-> irq_req)
      else $error("overflow request blocked with everything enabled");

   AST_ADC_SET: assert property (
      @(posedge mclk) disable iff (!rst_b)
      adc_done_evt |=> flags_r[6])
      else $error("A/D flag not set on completion");

   AST_PERIOD_SET: assert property (
      @(posedge mclk) disable iff (!rst_b)
      period_match_evt |=> flags_r[1])
      else $error("period match flag not set on match");

   AST_OVF_SET: assert property (
      @(posedge mclk) disable iff (!rst_b)
      wide_timer_ovf_evt |=> flags_r[0])
      else $error("overflow flag not set on overflow");

   AST_SERIAL_STICKY: assert property (
      @(posedge mclk) disable iff (!rst_b)
      flags_r[3] && !(reg_wr && sel_flags) |=> flags_r[3])
      else $error("serial flag dropped without a software write");

   AST_CAPCMP_STICKY: assert property (
      @(posedge mclk) disable iff (!rst_b)
      flags_r[2] && !(reg_wr && sel_flags) |=> flags_r[2])
      else $error("capture/compare flag dropped without a software write");

   AST_PERIOD_STICKY: assert property (
      @(posedge mclk) disable iff (!rst_b)
      flags_r[1] && !(reg_wr && sel_flags) |=> flags_r[1])
      else $error("period match flag dropped without a software write");

   AST_FLAGS_NO_WRITE: assert property (
      @(posedge mclk) disable iff (!rst_b)
      !(reg_wr && sel_flags) |=> flags_r == ($past(flags_r) | $past(event_vec)))
      else $error("flags changed other than by events");

   AST_FLAGS_WRITE: assert property (
      @(posedge mclk) disable iff (!rst_b)
      reg_wr && sel_flags |=> flags_r == (($past(reg_wdata) & 8'h4F) | $past(event_vec)))
      else $error("flag register write not stored");

   AST_ENABLES_WRITE: assert property (
      @(posedge mclk) disable iff (!rst_b)
      reg_wr && sel_enables |=> enables_r == ($past(reg_wdata) & 8'h4F))
      else $error("enable register write not stored");

   AST_ENABLES_READ_ADDR: assert property (
      @(posedge mclk) disable iff (!rst_b)
      reg_rd && reg_addr == 8'h8C |=> reg_rdata == $past(enables_r))
      else $error("enable register read returned wrong data");

   AST_RDATA_UNIMPL_ZERO: assert property (
      @(posedge mclk) disable iff (!rst_b)
      reg_rd && (sel_flags || sel_enables) |=> (reg_rdata & 8'hB0) == 8'h00)
      else $error("unimplemented bit read back as one");

   AST_BROWNOUT_BEATS_WRITE: assert property (
      @(posedge mclk) disable iff (!rst_b)
      brownout_reset |=> !brownout_flag_r)
      else $error("brown-out flag not cleared by brown-out reset");

   AST_POWER_ON_WRITE: assert property (
      @(posedge mclk) disable iff (!rst_b)
      wr_reset_cause |=> power_on_flag_r == $past(reg_wdata[1]))
      else $error("power-on flag write not stored");

   COV_IRQ_RAISED: cover property (
      @(posedge mclk) disable iff (!rst_b)
      !irq_req ##1 irq_req);

   COV_SET_BEATS_CLEAR: cover property (
      @(posedge mclk) disable iff (!rst_b)
      adc_done_evt && reg_wr && sel_flags && !reg_wdata[6]);

   COV_BROWNOUT_SEEN: cover property (
      @(posedge mclk) disable iff (!rst_b)
      power_on_flag_r && brownout_flag_r ##1 brownout_reset ##1 !brownout_flag_r);

   COV_PWM_EVENT: cover property (
      @(posedge mclk) disable iff (!rst_b)
      capcmp_evt && capcmp_pwm_mode);

   COV_BACK_TO_BACK: cover property (
      @(posedge mclk) disable iff (!rst_b)
      reg_wr ##1 reg_rd);

endmodule : peripheral_interrupt_flags
`default_nettype wire

// *** sim/event_source_model.sv ***
// peripheral event sources firing one-cycle completion pulses on request
`default_nettype none
module event_source_model (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic fire,
   input wire logic [4:0] which,
   output logic adc_done_evt,
   output logic serial_done_evt,
   output logic capcmp_evt,
   output logic period_match_evt,
   output logic wide_timer_ovf_evt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] evt_r;
   // registered, so a pulse lasts as many cycles as fire is held: one cycle from the pulse task, as a peripheral would give
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         evt_r <= 5'h00;
      end else begin
         evt_r <= fire ? which : 5'h00;
      end
   end
   assign {adc_done_evt, serial_done_evt, capcmp_evt, period_match_evt, wide_timer_ovf_evt} = evt_r;
endmodule : event_source_model
`default_nettype wire

// *** sim/tb_top.sv ***
// bench for the peripheral interrupt flag and enable block
`default_nettype none
module tb_top import periph_irq_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] SRC_BIT [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h40};
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic capcmp_pwm_mode = 1'b0;
   logic brownout_reset = 1'b0;
   logic fire = 1'b0;
   logic [4:0] which = 5'h00;
   logic [7:0] reg_rdata;
   logic irq_req;
   logic adc_ev, ser_ev, cc_ev, per_ev, ovf_ev;
   logic [7:0] rv;
   int errors = 0;
   int n_tests = 0;
   always #5 mclk = ~mclk;
   peripheral_interrupt_flags u_peripheral_interrupt_flags (.mclk(mclk), .rst_b(rst_b),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .adc_done_evt(adc_ev), .serial_done_evt(ser_ev),
      .capcmp_evt(cc_ev), .capcmp_pwm_mode(capcmp_pwm_mode), .period_match_evt(per_ev),
      .wide_timer_ovf_evt(ovf_ev), .brownout_reset(brownout_reset), .irq_req(irq_req));
   event_source_model u_event_source_model (.mclk(mclk), .rst_b(rst_b), .fire(fire),
      .which(which), .adc_done_evt(adc_ev), .serial_done_evt(ser_ev), .capcmp_evt(cc_ev),
      .period_match_evt(per_ev), .wide_timer_ovf_evt(ovf_ev));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // bus tasks start just after a rising edge and end just after one
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
      @(posedge mclk);
   endtask : rd
   task automatic pulse(input logic [4:0] v);
      which <= v;
      fire <= 1'b1;
      @(posedge mclk);
      fire <= 1'b0;
      @(posedge mclk);
   endtask : pulse
   task automatic chk_irq(input logic exp);
      #1 check({7'h00, irq_req}, {7'h00, exp});
      @(posedge mclk);
   endtask : chk_irq
   task automatic t_reset;
      rd(ADDR_PERIPHERAL_IRQ_FLAGS);
      check(rv, 8'h00);
      rd(ADDR_PERIPHERAL_IRQ_ENABLES);
      check(rv, 8'h00);
      rd(ADDR_CORE_IRQ_CONTROL);
      check(rv, 8'h00);
      rd(ADDR_RESET_CAUSE_FLAGS);
      // brown-out bit is undefined after power-on, so only the power-on bit is judged
      check(rv & 8'h02, 8'h00);
      rd(8'h55);
      check(rv, 8'h00);
   endtask : t_reset
   task automatic t_reserved;
      wr(ADDR_PERIPHERAL_IRQ_FLAGS, 8'hFF);
      wr(ADDR_PERIPHERAL_IRQ_ENABLES, 8'hFF);
      chk_irq(1'b0);
      rd(ADDR_PERIPHERAL_IRQ_FLAGS);
      check(rv, 8'h4F);
      rd(ADDR_PERIPHERAL_IRQ_ENABLES);
      check(rv, 8'h4F);
      wr(ADDR_CORE_IRQ_CONTROL, 8'hC0);
      chk_irq(1'b1);
      wr(ADDR_PERIPHERAL_IRQ_ENABLES, 8'h00);
      wr(ADDR_PERIPHERAL_IRQ_FLAGS, 8'h00);
   endtask : t_reserved
   task automatic t_sources;
      logic [7:0] m;
      for (int i = 0; i < 5; i++) begin
         m = SRC_BIT[i];
         pulse(5'(1 << i));
         chk_irq(1'b0);
         rd(ADDR_PERIPHERAL_IRQ_FLAGS);
         check(rv, m);
         wr(ADDR_PERIPHERAL_IRQ_ENABLES, ~m & 8'h4F);
         chk_irq(1'b0);
         wr(ADDR_PERIPHERAL_IRQ_ENABLES, m);
         chk_irq(1'b1);
         wr(ADDR_CORE_IRQ_CONTROL, 8'h80);
         chk_irq(1'b0);
         wr(ADDR_CORE_IRQ_CONTROL, 8'h40);
         chk_irq(1'b0);
         wr(ADDR_CORE_IRQ_CONTROL, 8'hC0);
         chk_irq(1'b1);
         wr(ADDR_PERIPHERAL_IRQ_FLAGS, 8'h00);
         chk_irq(1'b0);
         wr(ADDR_PERIPHERAL_IRQ_ENABLES, 8'h00);
      end
   endtask : t_sources
   task automatic t_pwm;
      capcmp_pwm_mode <= 1'b1;
      pulse(5'h04);
      rd(ADDR_PERIPHERAL_IRQ_FLAGS);
      check(rv, 8'h00);
      capcmp_pwm_mode <= 1'b0;
   endtask : t_pwm
   task automatic t_brownout;
      wr(ADDR_RESET_CAUSE_FLAGS, 8'h03);
      rd(ADDR_RESET_CAUSE_FLAGS);
      check(rv, 8'h03);
      brownout_reset <= 1'b1;
      @(posedge mclk);
      brownout_reset <= 1'b0;
      @(posedge mclk);
      rd(ADDR_RESET_CAUSE_FLAGS);
      check(rv, 8'h02);
   endtask : t_brownout
   task automatic t_set_wins;
      which <= 5'h12;
      fire <= 1'b1;
      @(posedge mclk);
      // events land in the same cycle as the clearing write
      fire <= 1'b0;
      reg_addr <= ADDR_PERIPHERAL_IRQ_FLAGS;
      reg_wdata <= 8'h00;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
      rd(ADDR_PERIPHERAL_IRQ_FLAGS);
      check(rv, 8'h42);
      wr(ADDR_PERIPHERAL_IRQ_FLAGS, 8'h00);
   endtask : t_set_wins
   task automatic t_back_to_back;
      reg_addr <= ADDR_PERIPHERAL_IRQ_ENABLES;
      reg_wdata <= 8'hB5;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, 8'h05);
      @(posedge mclk);
      #1 check(reg_rdata, 8'h00);
      @(posedge mclk);
      wr(ADDR_PERIPHERAL_IRQ_ENABLES, 8'h00);
   endtask : t_back_to_back
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict
   initial begin
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      t_reset();
      t_reserved();
      t_sources();
      t_pwm();
      t_brownout();
      t_set_wins();
      t_back_to_back();
      give_verdict();
   end
   // whole run is well under a thousand cycles
   initial begin
      #100000;
      errors++;
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
